/* File: ulpi_link_pkg.sv */
/*
 * constants and types shared by the ULPI link port, its FIFO and its clock
 * gate. assumes nothing beyond a SystemVerilog compiler.
 */
package ulpi_link_pkg;
    localparam int BYTE_W = 8;
    // word through the FIFO and crossings: end flag above the byte
    localparam int WORD_W = 9;
    localparam int END_BIT = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_CNT_W = 3;
    localparam int FIFO_PTR_W = 2;
    localparam int LINK_MHZ = 60;
    localparam int HS_MBPS = 480;
    localparam int RX_LAT_HS_BITS = 43;
    // longest time, so rounded down: 43 * 60 / 480 = 5 interface cycles
    localparam int RX_LAT_LINK_CYC = RX_LAT_HS_BITS * LINK_MHZ / HS_MBPS;
    localparam logic [BYTE_W-1:0] BUS_IDLE = 8'h00;
    localparam logic [3:0] REF_OK_EDGES = 4'hC;
    localparam logic [3:0] REF_CNT_ONE = 4'h1;
    localparam logic [FIFO_PTR_W-1:0] PTR_ONE = 2'h1;
    localparam logic [FIFO_CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [FIFO_CNT_W-1:0] CNT_FULL = 3'h4;

    typedef enum logic [5:0] {
        BS_OFF = 6'h01,
        BS_IDLE = 6'h02,
        BS_TAKE = 6'h04,
        BS_TURN_UP = 6'h08,
        BS_SEND = 6'h10,
        BS_TURN_DN = 6'h20
    } bus_state_t;
endpackage

/* File: word_fifo.sv */
/*
 * small single-clock FIFO with valid/ready on both sides.
 * assumes both sides run on clk and that ce freezes it as a whole.
 */
`timescale 1ns/1ps
`default_nettype none
module word_fifo
    import ulpi_link_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [FIFO_PTR_W-1:0] wr;
        logic [FIFO_PTR_W-1:0] rd;
        logic [FIFO_CNT_W-1:0] cnt;
    } fifo_t;

    fifo_t q, d;
    logic push, pop;

    assign in_ready = (q.cnt != CNT_FULL);
    assign out_valid = (q.cnt != '0);
    // read data straight from the storage flops
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + PTR_ONE;
        end
        if (pop) begin
            d.rd = q.rd + PTR_ONE;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + CNT_ONE;
        end else if (pop && !push) begin
            d.cnt = q.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* File: iface_clk_gate.sv */
/*
 * glitch-free gate for the interface clock sent to the link.
 * assumes en is synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module iface_clk_gate
    import ulpi_link_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n,
    input wire logic en,
    output logic clk_out
);
    typedef struct packed {
        logic en;
    } gate_t;

    gate_t q, d;

    always_comb begin
        d = q;
        d.en = en;
    end

    // enable moves only while the clock is low, so no runt pulses
    always_ff @(negedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clk_out = clk_in && q.en;
endmodule
`default_nettype wire

/* File: ulpi_phy_link_port.sv */
/*
 * link-facing ULPI port of a USB transceiver: bus turnaround, NXT throttle,
 * STP handling, suspend and sleep tri-state, VBUS supply enable.
 * assumes LINK_CLK is the transceiver's own 60 MHz PLL clock, CLK the
 * 100 MHz core clock, and that pad logic resolves the enables to wires.
 */
// Functional notes
// - interface clock of 60 MHz goes out; all bus outputs leave flip-flops
// - internal timing is qualified by a 13 MHz reference from the link
// - single data rate ULPI: one byte per interface clock cycle
// - commands and status travel in-band; clock, eight data, three control
// - data bus is eight bits, bit 7 most significant, two-way
// - with bytes for the link, DIR goes high and the bus is ours
// - with nothing to send, DIR stays low and the bus is watched
// - NXT is high in the cycle a link byte is accepted
// - STP follows the last byte; the previous cycle's byte was last
// - suspend reset low: suspended, every interface output tri-stated; the code stops the interface clock and holds it low, not tri-stated
// - sleep tri-states all interface pins; the code stops the interface clock and holds it low, not tri-stated
// - VBUS supply enable is active high and low after reset
// - receive data reaches the bus within 43 high-speed bit times
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_link_port
    import ulpi_link_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic LINK_CLK,
    input wire logic REF_CLK_13M,
    input wire logic SUSPEND_RESET_N,
    input wire logic SLEEP,
    input wire logic VBUS_ON,
    output logic VBUS_SUPPLY_EN,
    output logic IFACE_CLK_60M,
    input wire logic UP_VALID,
    input wire logic [BYTE_W-1:0] UP_DATA,
    input wire logic UP_LAST,
    output logic UP_READY,
    output logic DN_VALID,
    output logic [BYTE_W-1:0] DN_DATA,
    output logic DN_END,
    input wire logic DN_READY,
    output logic ULPI_DIR,
    output logic ULPI_DIR_OE,
    output logic ULPI_NXT,
    output logic ULPI_NXT_OE,
    input wire logic ULPI_STP,
    input wire logic [BYTE_W-1:0] ULPI_DATA_I,
    output logic [BYTE_W-1:0] ULPI_DATA_O,
    output logic ULPI_DATA_OE
);
    localparam int LAT_MAX = RX_LAT_LINK_CYC;

    // toggle handshakes: a side has work while the two toggles differ
    function automatic logic toggle_open(input logic req, input logic ack);
        toggle_open = (req != ack);
    endfunction

    typedef struct packed {
        logic up_req;
        logic [WORD_W-1:0] up_word;
        logic [1:0] up_ack_sy;
        logic [1:0] dn_req_sy;
        logic dn_ack;
        logic dn_valid;
        logic [WORD_W-1:0] dn_word;
        logic vbus_en;
    } core_t;

    typedef struct packed {
        logic [1:0] ce_sy;
        logic [1:0] susp_sy;
        logic [1:0] sleep_sy;
        logic [1:0] ref_sy;
        logic ref_prev;
        logic [3:0] ref_cnt;
        logic ref_ok;
        logic [1:0] up_req_sy;
        logic up_ack;
        logic [1:0] dn_ack_sy;
        logic dn_req;
        logic [WORD_W-1:0] dn_word;
        logic end_pend;
        bus_state_t st;
        logic pins_oe;
        logic dir;
        logic nxt;
        logic data_oe;
        logic [BYTE_W-1:0] dout;
        logic last;
    } link_t;

    core_t cq, cd;
    link_t lq, ld;
    logic fifo_in_valid, fifo_in_ready;
    logic fifo_out_valid, fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic slot_free, running;

    // core clock domain: user streams and the supply enable

    // a word is held in up_word until the link side has taken it
    assign UP_READY = CE && !toggle_open(cq.up_req, cq.up_ack_sy[1]);
    assign DN_VALID = cq.dn_valid;
    assign DN_DATA = cq.dn_word[BYTE_W-1:0];
    assign DN_END = cq.dn_word[END_BIT];
    assign VBUS_SUPPLY_EN = cq.vbus_en;

    always_comb begin
        cd = cq;
        cd.up_ack_sy = {cq.up_ack_sy[0], lq.up_ack};
        cd.dn_req_sy = {cq.dn_req_sy[0], lq.dn_req};
        cd.vbus_en = VBUS_ON;
        if (UP_VALID && UP_READY) begin
            cd.up_word = {UP_LAST, UP_DATA};
            cd.up_req = !cq.up_req;
        end
        if (cq.dn_valid && DN_READY) begin
            cd.dn_valid = 1'b0;
            cd.dn_ack = !cq.dn_ack;
        end else if (!cq.dn_valid
                     && toggle_open(cq.dn_req_sy[1], cq.dn_ack)) begin
            // link word is stable until our ack returns
            cd.dn_word = lq.dn_word;
            cd.dn_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cq <= '0;
        end else if (CE) begin
            cq <= cd;
        end
    end

    // link clock domain: the ULPI bus itself

    assign fifo_in_valid = toggle_open(lq.up_req_sy[1], lq.up_ack);
    assign slot_free = !toggle_open(lq.dn_req, lq.dn_ack_sy[1]);
    // no interface activity until the reference is seen toggling
    assign running = lq.susp_sy[1] && !lq.sleep_sy[1] && lq.ref_ok;

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_up_fifo (
        .clk(LINK_CLK),
        .rst_n(RST_N),
        .ce(lq.ce_sy[1]),
        .in_valid(fifo_in_valid),
        .in_data(cq.up_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    always_comb begin
        ld = lq;
        fifo_out_ready = 1'b0;
        ld.ce_sy = {lq.ce_sy[0], CE};
        if (lq.ce_sy[1]) begin
            ld.susp_sy = {lq.susp_sy[0], SUSPEND_RESET_N};
            ld.sleep_sy = {lq.sleep_sy[0], SLEEP};
            ld.ref_sy = {lq.ref_sy[0], REF_CLK_13M};
            ld.up_req_sy = {lq.up_req_sy[0], cq.up_req};
            ld.dn_ack_sy = {lq.dn_ack_sy[0], cq.dn_ack};
            ld.ref_prev = lq.ref_sy[1];
            if (lq.ref_sy[1] && !lq.ref_prev && !lq.ref_ok) begin
                ld.ref_cnt = lq.ref_cnt + REF_CNT_ONE;
                ld.ref_ok = (ld.ref_cnt == REF_OK_EDGES);
            end
            if (fifo_in_valid && fifo_in_ready) begin
                ld.up_ack = !lq.up_ack;
            end
            unique case (lq.st)
                BS_OFF: begin
                    if (running) begin
                        ld.st = BS_IDLE;
                        ld.pins_oe = 1'b1;
                    end
                end
                BS_IDLE: begin
                    // a link transmit command outranks our own traffic
                    if (ULPI_DATA_I != BUS_IDLE) begin
                        ld.st = BS_TAKE;
                        ld.nxt = slot_free;
                    end else if (fifo_out_valid) begin
                        ld.st = BS_TURN_UP;
                        ld.dir = 1'b1;
                    end
                end
                BS_TAKE: begin
                    if (ULPI_STP || lq.end_pend) begin
                        // byte under STP is never data; close the stream
                        ld.nxt = 1'b0;
                        if (slot_free) begin
                            ld.dn_word = {1'b1, BUS_IDLE};
                            ld.dn_req = !lq.dn_req;
                            ld.end_pend = 1'b0;
                            ld.st = BS_IDLE;
                        end else begin
                            ld.end_pend = 1'b1;
                        end
                    end else if (lq.nxt) begin
                        // byte under NXT is taken now
                        ld.dn_word = {1'b0, ULPI_DATA_I};
                        ld.dn_req = !lq.dn_req;
                        ld.nxt = 1'b0;
                    end else begin
                        ld.nxt = slot_free;
                    end
                end
                BS_TURN_UP, BS_SEND: begin
                    ld.st = BS_SEND;
                    ld.data_oe = 1'b1;
                    if (lq.last) begin
                        ld.st = BS_TURN_DN;
                        ld.dir = 1'b0;
                        ld.data_oe = 1'b0;
                        ld.nxt = 1'b0;
                        ld.last = 1'b0;
                    end else if (fifo_out_valid) begin
                        // one byte per cycle, NXT marks data
                        fifo_out_ready = 1'b1;
                        ld.dout = fifo_out_data[BYTE_W-1:0];
                        ld.nxt = 1'b1;
                        ld.last = fifo_out_data[END_BIT];
                    end else begin
                        // underrun: hold the bus, idle byte without NXT
                        ld.dout = BUS_IDLE;
                        ld.nxt = 1'b0;
                    end
                end
                BS_TURN_DN: begin
                    ld.st = BS_IDLE;
                end
                default: begin
                    ld.st = BS_OFF;
                end
            endcase
            if (!running) begin
                ld.st = BS_OFF;
                ld.pins_oe = 1'b0;
                ld.dir = 1'b0;
                ld.nxt = 1'b0;
                ld.data_oe = 1'b0;
                ld.last = 1'b0;
                ld.end_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lq <= '0;
            lq.st <= BS_OFF;
        end else begin
            lq <= ld;
        end
    end

    // every bus output below is a flip-flop on the interface clock
    assign ULPI_DIR = lq.dir;
    assign ULPI_DIR_OE = lq.pins_oe;
    assign ULPI_NXT = lq.nxt;
    assign ULPI_NXT_OE = lq.pins_oe;
    assign ULPI_DATA_O = lq.dout;
    assign ULPI_DATA_OE = lq.data_oe;

    // clock to the link stops while the pins are tri-stated
    iface_clk_gate u_clk_gate (
        .clk_in(LINK_CLK),
        .rst_n(RST_N),
        .en(lq.pins_oe),
        .clk_out(IFACE_CLK_60M)
    );

    // checks on the link clock, plus one on the core clock for the supply enable

    sequence s_turn_up;
        $rose(lq.dir) ##1 lq.dir;
    endsequence

    sequence s_stop_taken;
        (lq.st == BS_TAKE) && ULPI_STP && lq.ce_sy[1];
    endsequence

    a_dir_turnaround: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        $rose(lq.dir) |-> !lq.data_oe && !lq.nxt)
        else $error("bus driven in the turnaround cycle");

    a_idle_dir_low: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        (lq.st == BS_IDLE || lq.st == BS_TAKE) |-> !lq.dir && !lq.data_oe)
        else $error("bus not released while link may drive");

    a_nxt_slot_free: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        lq.nxt && !lq.dir |-> slot_free)
        else $error("NXT raised with no room for the byte");

    a_nxt_takes_byte: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        lq.nxt && !lq.dir && !ULPI_STP && lq.ce_sy[1]
            && lq.st == BS_TAKE
        |=> $changed(lq.dn_req)
            && lq.dn_word == {1'b0, $past(ULPI_DATA_I)})
        else $error("byte under NXT was not taken");

    a_stop_closes: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        s_stop_taken |=> !lq.nxt ##[0:40] (lq.st != BS_TAKE))
        else $error("stream not closed after STP");

    a_off_tristate: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        (lq.st == BS_OFF) |-> !ULPI_DIR_OE && !ULPI_NXT_OE && !ULPI_DATA_OE)
        else $error("interface driven while off");

    a_suspend_off: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        !lq.susp_sy[1] && lq.ce_sy[1] |=> (lq.st == BS_OFF) && !lq.pins_oe)
        else $error("suspend did not tri-state the port");

    a_send_latency: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        $rose(fifo_out_valid) && lq.st == BS_IDLE && lq.ce_sy[1]
            && ULPI_DATA_I == BUS_IDLE && running
        |-> ##[1:LAT_MAX] lq.dir)
        else $error("receive byte late to the bus");

    a_send_data: assert property (@(posedge LINK_CLK)
        disable iff (!RST_N)
        s_turn_up |-> lq.data_oe)
        else $error("data not driven after turnaround");

    a_vbus_follow: assert property (@(posedge CLK)
        disable iff (!RST_N)
        CE |=> VBUS_SUPPLY_EN == $past(VBUS_ON))
        else $error("supply enable does not follow request");
endmodule
`default_nettype wire

/* File: ulpi_link_model.sv */
/*
 * behavioural link controller on the ULPI bus: sends queued bytes to the
 * transceiver and collects the bytes it sends. assumes the bench resolves
 * the data bus from both enables, with the pull-down when released.
 */
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
    input wire logic clk,
    input wire logic dir,
    input wire logic nxt,
    input wire logic [7:0] bus_in,
    output logic stp,
    output logic [7:0] data_o,
    output logic data_oe
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    int gap = 0;
    int idle_cnt = 0;
    logic took;
    logic rx_hit;
    logic [7:0] seen;

    initial begin
        stp = 1'b0;
        data_o = 8'h00;
        data_oe = 1'b0;
    end

    always @(posedge clk) begin
        took = data_oe && nxt && !dir && !stp;
        rx_hit = dir && nxt;
        seen = bus_in;
        #1;
        if (rx_hit) begin
            rx_q.push_back(seen);
        end
        if (stp) begin
            stp = 1'b0;
            data_oe = 1'b0;
            data_o = ~data_o;
        end else if (dir) begin
            data_oe = 1'b0;
        end else if (took) begin
            void'(tx_q.pop_front());
            if (tx_q.size() == 0) begin
                stp = 1'b1;
                data_o = 8'h00;
            end else begin
                data_o = tx_q[0];
            end
        end else if (!data_oe && tx_q.size() > 0) begin
            // slow start only: once a byte is taken the next must follow
            if (idle_cnt >= gap) begin
                data_oe = 1'b1;
                data_o = tx_q[0];
                idle_cnt = 0;
            end else begin
                idle_cnt++;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_ulpi_phy_link_port.sv */
/*
 * self-checking bench for the ULPI link port: both stream directions,
 * sleep and suspend tri-state, supply enable. assumes the link model
 * file and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_ulpi_phy_link_port
    import ulpi_link_pkg::*;
;
    logic CLK = 0;
    logic LINK_CLK = 0;
    logic REF_CLK_13M = 0;
    logic RST_N = 0;
    logic CE = 1;
    logic SUSPEND_RESET_N = 1;
    logic SLEEP = 0;
    logic VBUS_ON = 0;
    logic UP_VALID = 0;
    logic [7:0] UP_DATA = 8'h00;
    logic UP_LAST = 0;
    logic DN_READY = 0;
    logic VBUS_SUPPLY_EN, IFACE_CLK_60M, UP_READY, DN_VALID, DN_END;
    logic [7:0] DN_DATA, ULPI_DATA_O;
    logic ULPI_DIR, ULPI_DIR_OE, ULPI_NXT, ULPI_NXT_OE, ULPI_DATA_OE;
    logic lnk_stp, lnk_oe;
    logic [7:0] lnk_d;
    wire logic [7:0] bus;
    wire logic dir_w;
    wire logic nxt_w;
    logic [15:0] lfsr = 16'h21F0;
    logic [15:0] rdy_s = 16'h21F0;
    logic [8:0] dn_q[$];
    logic [7:0] exp_q[$];
    int ifc_cnt = 0;
    int error_cnt = 0;
    int num_checks = 0;

    always #5 CLK = ~CLK;
    initial #3.3 forever #6 LINK_CLK = ~LINK_CLK;
    always #38.46 REF_CLK_13M = ~REF_CLK_13M;

    // released data lines fall to the pull-down level
    assign bus = ULPI_DATA_OE ? ULPI_DATA_O : (lnk_oe ? lnk_d : 8'h00);
    assign dir_w = ULPI_DIR_OE & ULPI_DIR;
    assign nxt_w = ULPI_NXT_OE & ULPI_NXT;

    ulpi_phy_link_port u_ulpi_phy_link_port (
        .CLK(CLK), .RST_N(RST_N), .CE(CE), .LINK_CLK(LINK_CLK),
        .REF_CLK_13M(REF_CLK_13M), .SUSPEND_RESET_N(SUSPEND_RESET_N),
        .SLEEP(SLEEP), .VBUS_ON(VBUS_ON), .VBUS_SUPPLY_EN(VBUS_SUPPLY_EN),
        .IFACE_CLK_60M(IFACE_CLK_60M), .UP_VALID(UP_VALID),
        .UP_DATA(UP_DATA), .UP_LAST(UP_LAST), .UP_READY(UP_READY),
        .DN_VALID(DN_VALID), .DN_DATA(DN_DATA), .DN_END(DN_END),
        .DN_READY(DN_READY), .ULPI_DIR(ULPI_DIR), .ULPI_DIR_OE(ULPI_DIR_OE),
        .ULPI_NXT(ULPI_NXT), .ULPI_NXT_OE(ULPI_NXT_OE), .ULPI_STP(lnk_stp),
        .ULPI_DATA_I(bus), .ULPI_DATA_O(ULPI_DATA_O),
        .ULPI_DATA_OE(ULPI_DATA_OE)
    );

    ulpi_link_model u_ulpi_link_model (
        .clk(IFACE_CLK_60M), .dir(dir_w), .nxt(nxt_w), .bus_in(bus),
        .stp(lnk_stp), .data_o(lnk_d), .data_oe(lnk_oe)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // stream end word carries no data
    function automatic logic [8:0] exp_dn(input logic [7:0] b,
        input logic fin);
        return fin ? 9'h100 : {1'b0, b};
    endfunction

    always @(posedge IFACE_CLK_60M) ifc_cnt++;

    always @(posedge CLK) begin
        if (DN_VALID === 1'b1 && DN_READY === 1'b1) begin
            dn_q.push_back({DN_END, DN_DATA});
        end
        #1;
        rdy_s = lfsr_next(rdy_s);
        DN_READY = rdy_s[3] | rdy_s[9];
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic wait_up();
        int i;
        for (i = 0; i < 3000 && ULPI_DIR_OE !== 1'b1; i++) wait_clk(1);
        chk({8'h00, ULPI_DIR_OE}, 9'h001);
    endtask

    task automatic up_send(input logic [7:0] b, input logic last);
        int i;
        wait_clk(1);
        UP_VALID = 1'b1;
        UP_DATA = b;
        UP_LAST = last;
        i = 0;
        do begin
            @(posedge CLK);
            i++;
        end while (UP_READY !== 1'b1 && i < 500);
        #1;
        UP_VALID = 1'b0;
        if (i >= 500) chk(9'h000, 9'h001);
    endtask

    initial begin
        #900000;
        error_cnt++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        results();
    end

    initial begin
        int k, n, i, j, e;
        int lens[3] = '{1, 4, 6};
        wait_clk(10);
        // supply asked for while reset must still hold it off
        VBUS_ON = 1'b1;
        wait_clk(10);
        chk({8'h00, VBUS_SUPPLY_EN}, 9'h000);
        RST_N = 1'b1;
        wait_clk(1);
        chk({8'h00, VBUS_SUPPLY_EN}, 9'h001);
        // enable low: the supply flop must not follow the request
        CE = 1'b0;
        VBUS_ON = 1'b0;
        wait_clk(3);
        chk({8'h00, VBUS_SUPPLY_EN}, 9'h001);
        CE = 1'b1;
        wait_clk(1);
        chk({8'h00, VBUS_SUPPLY_EN}, 9'h000);
        VBUS_ON = 1'b1;
        wait_up();
        wait_clk(5);
        chk({7'h00, ULPI_DIR, ULPI_DATA_OE}, 9'h000);
        $display("test 1 done");
        for (k = 0; k < 3; k++) begin
            // PHY to link, the 6-byte run longer than the FIFO so back pressure shows
            n = lens[k];
            exp_q.delete();
            for (i = 0; i < n; i++) begin
                lfsr = lfsr_next(lfsr);
                exp_q.push_back(lfsr[7:0]);
                up_send(lfsr[7:0], i == n - 1);
            end
            for (j = 0; j < 400 && u_ulpi_link_model.rx_q.size() < n; j++)
                wait_clk(1);
            chk(u_ulpi_link_model.rx_q.size(), n);
            for (i = 0; i < n && i < u_ulpi_link_model.rx_q.size(); i++)
                chk(u_ulpi_link_model.rx_q[i], exp_q[i]);
            u_ulpi_link_model.rx_q.delete();
            wait_clk(10);
            chk({8'h00, ULPI_DIR}, 9'h000);
            // link to PHY, first byte nonzero so it reads as a command
            exp_q.delete();
            dn_q.delete();
            u_ulpi_link_model.gap = k * 3;
            for (i = 0; i < n; i++) begin
                lfsr = lfsr_next(lfsr);
                exp_q.push_back(i == 0 ? (lfsr[7:0] | 8'h01) : lfsr[7:0]);
                u_ulpi_link_model.tx_q.push_back(exp_q[i]);
            end
            for (j = 0; j < 600 && dn_q.size() < n + 1; j++) wait_clk(1);
            chk(dn_q.size(), n + 1);
            for (i = 0; i < dn_q.size() && i <= n; i++) begin
                e = (i == n);
                j = (i < n) ? exp_q[i] : 0;
                chk(dn_q[i], exp_dn(j[7:0], e[0]));
            end
            $display("test %0d done", k + 2);
        end
        i = ifc_cnt;
        wait_clk(60);
        chk(((ifc_cnt - i) >= 48 && (ifc_cnt - i) <= 52), 9'h001);
        for (k = 0; k < 2; k++) begin
            if (k == 0) SLEEP = 1'b1;
            else SUSPEND_RESET_N = 1'b0;
            wait_clk(20);
            e = {ULPI_DIR_OE, ULPI_NXT_OE, ULPI_DATA_OE};
            chk(e[8:0], 9'h000);
            i = ifc_cnt;
            wait_clk(40);
            chk(ifc_cnt - i, 9'h000);
            SLEEP = 1'b0;
            SUSPEND_RESET_N = 1'b1;
            wait_up();
            $display("test %0d done", k + 5);
        end
        results();
    end
endmodule
`default_nettype wire
